// ===== core/pif_defs.vh
`ifndef PIF_DEFS_VH
`define PIF_DEFS_VH

// Register offsets on the local register port
`define PIF_ADDR_FLAGS   4'h0
`define PIF_ADDR_MASK    4'h1
`define PIF_ADDR_STATUS  4'h2
`define PIF_ADDR_WIDTH   4

// Flag register bit positions
`define PIF_BIT_TMR      5
`define PIF_BIT_PCS      4
`define PIF_BIT_EXT      0

// Reset values
`define PIF_FLAGS_RESET  8'h00
`define PIF_MASK_RESET   8'h00
`define PIF_STATUS_RESET 8'h00

`endif

// ===== core/pif_sync.v
`timescale 1ns/10ps
// Two-stage synchroniser for a level from outside the clock domain
module pif_sync (
  // System
  clk,
  reset,
  // Data
  asyncIn,
  syncOut
);
  input  wire clk;
  input  wire reset;
  input  wire asyncIn;
  output wire syncOut;

  reg stage1Reg;
  reg stage2Reg;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1Reg <= 1'b0;
      stage2Reg <= 1'b0;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;
endmodule

// ===== core/pif_flags.v
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "pif_defs.vh"

// How it works
// - Bits 7-6 read zero, no storage
// - Timer overflow sets bit 5
// - Timer flag held until software writes zero
// - Bit 4 read-only, writes ignored
// - Summary reads one if any pin flag set
// - Summary reads zero when no pin flag and no enabled edge
// - Only enabled edges join pin flags in the summary
// - Bits 3-1 read zero, no storage
// - External event sets bit 0
// - External flag held until software writes zero
module pif_flags #(
  parameter PIN_COUNT = 6
) (
  // System
  clk,
  reset,
  // Register port
  regAddr,
  regWrData,
  regWrStrobe,
  regRdStrobe,
  regRdData,
  // Events
  timerOverflow,
  extEventPin,
  pinChangeFlags,
  risingEdgeEnable,
  fallingEdgeEnable,
  risingEdgeSeen,
  fallingEdgeSeen,
  // Interrupt
  irq
);
  input  wire                        clk;
  input  wire                        reset;
  input  wire [`PIF_ADDR_WIDTH-1:0]  regAddr;
  input  wire [7:0]                  regWrData;
  input  wire                        regWrStrobe;
  input  wire                        regRdStrobe;
  output reg  [7:0]                  regRdData;
  input  wire                        timerOverflow;
  input  wire                        extEventPin;
  input  wire [PIN_COUNT-1:0]        pinChangeFlags;
  input  wire [PIN_COUNT-1:0]        risingEdgeEnable;
  input  wire [PIN_COUNT-1:0]        fallingEdgeEnable;
  input  wire [PIN_COUNT-1:0]        risingEdgeSeen;
  input  wire [PIN_COUNT-1:0]        fallingEdgeSeen;
  output reg                         irq;

  reg        timerFlagReg;
  reg        extFlagReg;
  reg        extLevelReg;
  reg        pinSummaryReg;
  reg  [7:0] maskReg;
  reg  [7:0] statusReg;
  reg  [7:0] statusNext;
  reg  [7:0] flagsView;
  wire       extSync;
  wire       extRise;
  wire       flagWrite;
  wire [PIN_COUNT-1:0] enabledEdges;
  wire       summaryNext;

  pif_sync extSyncInst (
    .clk     (clk),
    .reset   (reset),
    .asyncIn (extEventPin),
    .syncOut (extSync)
  );

  assign extRise   = extSync & ~extLevelReg;
  assign flagWrite = regWrStrobe && (regAddr == `PIF_ADDR_FLAGS);

  // Qualified edges also count, so the summary reacts in the edge cycle
  assign enabledEdges = (risingEdgeSeen & risingEdgeEnable) |
                        (fallingEdgeSeen & fallingEdgeEnable);
  assign summaryNext  = |(pinChangeFlags | enabledEdges);

  always @* begin
    flagsView = 8'h00;
    flagsView[`PIF_BIT_TMR] = timerFlagReg;
    flagsView[`PIF_BIT_PCS] = pinSummaryReg;
    flagsView[`PIF_BIT_EXT] = extFlagReg;
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      timerFlagReg  <= 1'b0;
      extFlagReg    <= 1'b0;
      extLevelReg   <= 1'b0;
      pinSummaryReg <= 1'b0;
    end else begin
      extLevelReg   <= extSync;
      pinSummaryReg <= summaryNext;
      if (timerOverflow) begin
        timerFlagReg <= 1'b1;
      end else if (flagWrite && !regWrData[`PIF_BIT_TMR]) begin
        timerFlagReg <= 1'b0;
      end
      if (extRise) begin
        extFlagReg <= 1'b1;
      end else if (flagWrite && !regWrData[`PIF_BIT_EXT]) begin
        extFlagReg <= 1'b0;
      end
    end
  end

  // Sticky status of set events; a read of it clears it, new events win
  always @* begin
    statusNext = statusReg;
    if (regRdStrobe && (regAddr == `PIF_ADDR_STATUS)) begin
      statusNext = 8'h00;
    end
    statusNext[`PIF_BIT_TMR] = statusNext[`PIF_BIT_TMR] | timerOverflow;
    statusNext[`PIF_BIT_EXT] = statusNext[`PIF_BIT_EXT] | extRise;
    statusNext[`PIF_BIT_PCS] = statusNext[`PIF_BIT_PCS] | (|enabledEdges);
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      statusReg <= `PIF_STATUS_RESET;
      maskReg   <= `PIF_MASK_RESET;
      regRdData <= 8'h00;
      irq       <= 1'b0;
    end else begin
      statusReg <= statusNext;
      irq       <= |(statusNext & maskReg);
      if (regWrStrobe && (regAddr == `PIF_ADDR_MASK)) begin
        maskReg <= regWrData;
      end
      if (regRdStrobe) begin
        case (regAddr)
          `PIF_ADDR_FLAGS:  regRdData <= flagsView;
          `PIF_ADDR_MASK:   regRdData <= maskReg;
          `PIF_ADDR_STATUS: regRdData <= statusReg;
          default:          regRdData <= 8'h00;
        endcase
      end else begin
        regRdData <= 8'h00;
      end
    end
  end
endmodule

// ===== tb/pif_flags_chk.sv
`timescale 1ns/10ps
module pif_flags_chk #(parameter PIN_COUNT = 6) (
  // System
  input wire                 clk,
  input wire                 reset,
  // Watched
  input wire [3:0]           regAddr,
  input wire                 regWrStrobe,
  input wire                 regRdStrobe,
  input wire [7:0]           regRdData,
  input wire                 timerOverflow,
  input wire [PIN_COUNT-1:0] pinChangeFlags,
  input wire [PIN_COUNT-1:0] risingEdgeEnable,
  input wire [PIN_COUNT-1:0] fallingEdgeEnable,
  input wire [PIN_COUNT-1:0] risingEdgeSeen,
  input wire [PIN_COUNT-1:0] fallingEdgeSeen
);
  wire       rdF = regRdStrobe && regAddr == 4'h0;
  wire       anyEdge = |((risingEdgeSeen & risingEdgeEnable) |
                         (fallingEdgeSeen & fallingEdgeEnable));
  wire [7:0] d   = regRdData;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_HI: assert property (rdF |=> d[7:6] == 2'h0) else $error("high bits");
  AST_MID: assert property (rdF |=> d[3:1] == 3'h0) else $error("mid bits");
  AST_TSET: assert property (timerOverflow ##1 rdF |=> d[5]) else $error("no set");
  AST_THOLD: assert property (rdF ##1 (rdF && d[5]) |=> d[5]) else $error("lost");
  AST_EHOLD: assert property (rdF ##1 (rdF && d[0]) |=> d[0]) else $error("lost");
  AST_PONE: assert property ((pinChangeFlags != 0)[*2] ##0 rdF |=> d[4]) else $error("low");
  AST_PZERO: assert property ((pinChangeFlags == 0 && !anyEdge)[*2] ##0 rdF |=> !d[4])
    else $error("high");
  AST_WIN: assert property ((timerOverflow && regWrStrobe && regAddr == 4'h0) ##1 rdF |=> d[5])
    else $error("lost");
endmodule

// ===== tb/pif_flags_tb.sv
`timescale 1ns/10ps
module pif_flags_tb;
  reg        clk = 1'h0, reset = 1'h1, regWrStrobe = 1'h0, regRdStrobe = 1'h0;
  reg        timerOverflow = 1'h0, extEventPin = 1'h0;
  reg  [3:0] regAddr = 4'h0;
  reg  [7:0] regWrData = 8'h00;
  reg  [5:0] pinChangeFlags = 6'h00;
  reg  [5:0] risingEdgeEnable = 6'h00, fallingEdgeEnable = 6'h00;
  reg  [5:0] risingEdgeSeen = 6'h00, fallingEdgeSeen = 6'h00;
  wire [7:0] regRdData;
  wire       irq;
  integer    errorCnt = 0, testsRun = 0, i;
  reg [14:0] rows [0:2] = '{15'h4020, 15'h0110, 15'h6030};
  always #20 clk = ~clk;
  pif_flags u_pif_flags (.*);
  task chk(input [7:0] g, e);
    begin
      testsRun = testsRun + 1;
      if (g !== e) begin
        errorCnt = errorCnt + 1;
        $display("unexpected at %0t: %h not %h", $time, g, e);
      end
    end
  endtask
  // One bus cycle; a read is compared against v
  task acc(input w, input [3:0] a, input [7:0] v);
    begin
      regAddr <= a;
      regWrData <= v;
      regWrStrobe <= w;
      regRdStrobe <= !w;
      @(posedge clk);
      regWrStrobe <= 1'h0;
      regRdStrobe <= 1'h0;
      #1;
      if (!w) chk(regRdData, v);
    end
  endtask
  task finishTest;
    begin
      $display("errors %0d checks %0d", errorCnt, testsRun);
      if (errorCnt == 0 && testsRun > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    errorCnt = errorCnt + 1;
    finishTest;
  end
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk) #1;
    for (i = 0; i < 3; i = i + 1) begin
      {timerOverflow, pinChangeFlags} <= rows[i][14:8];
      @(posedge clk) #1;
      timerOverflow <= 1'h0;
      acc(1'h0, 4'h0, rows[i][7:0]);
      pinChangeFlags <= 6'h00;
      acc(1'h1, 4'h0, 8'h00);
    end
    chk(irq, 8'h00);
    timerOverflow <= 1'h1;
    extEventPin <= 1'h1;
    acc(1'h1, 4'h0, 8'hFF);
    timerOverflow <= 1'h0;
    repeat (3) @(posedge clk);
    acc(1'h0, 4'h0, 8'h21);
    acc(1'h0, 4'h0, 8'h21);
    timerOverflow <= 1'h1;
    acc(1'h1, 4'h0, 8'h00);
    timerOverflow <= 1'h0;
    acc(1'h0, 4'h0, 8'h20);
    pinChangeFlags <= 6'h04;
    acc(1'h1, 4'h0, 8'h00);
    acc(1'h0, 4'h0, 8'h10);
    pinChangeFlags <= 6'h00;
    extEventPin <= 1'h0;
    // A falling edge on a pin enabled only for rising edges is ignored
    risingEdgeEnable <= 6'h01;
    fallingEdgeSeen <= 6'h01;
    @(posedge clk) #1;
    fallingEdgeSeen <= 6'h00;
    acc(1'h0, 4'h0, 8'h00);
    risingEdgeSeen <= 6'h01;
    @(posedge clk) #1;
    risingEdgeSeen <= 6'h00;
    acc(1'h0, 4'h0, 8'h10);
    reset <= 1'h1;
    @(posedge clk) #1;
    reset <= 1'h0;
    timerOverflow <= 1'h1;
    acc(1'h1, 4'h1, 8'h20);
    timerOverflow <= 1'h0;
    acc(1'h0, 4'hF, 8'h00);
    chk(irq, 8'h01);
    acc(1'h0, 4'h2, 8'h20);
    acc(1'h0, 4'h0, 8'h20);
    chk(irq, 8'h00);
    finishTest;
  end
endmodule
bind pif_flags pif_flags_chk #(.PIN_COUNT(PIN_COUNT)) u_pif_flags_chk (.*);
